// >>> tb/safe_absolute_position_config_test.sv
// Purpose: Self-checking bench for the safe absolute position block.
// Assumes: A short millisecond count so interval timing runs quickly.
// Notes: Scenarios run in a fixed order and each builds on the state left before.
`timescale 1ns/1ps
module safe_absolute_position_config_test;
    import spa_pkg::*;
    localparam int MT  = 12;
    localparam int MSC = 4;
    logic          mclk;
    logic          srst;
    logic [7:0]    regAddr;
    logic [31:0]   regWrData;
    logic          regWr;
    logic          regRd;
    logic [31:0]   regRdData;
    logic [MT-1:0] encTurns;
    logic          encStrobe;
    logic [3:0]    safeIn;
    logic [31:0]   absPosition;
    logic          absPosValid;
    logic          accelTick;
    logic          axisCfgEnabled;
    int            badCount;
    int            nTests;

    spa_abs_position #(.MT_BITS(MT), .MS_CYCLES_P(MSC)) dut_u (
        .mclk           (mclk),
        .srst           (srst),
        .regAddr        (regAddr),
        .regWrData      (regWrData),
        .regWr          (regWr),
        .regRd          (regRd),
        .regRdData      (regRdData),
        .encTurns       (encTurns),
        .encStrobe      (encStrobe),
        .safeIn         (safeIn),
        .absPosition    (absPosition),
        .absPosValid    (absPosValid),
        .accelTick      (accelTick),
        .axisCfgEnabled (axisCfgEnabled)
    );

    spa_enc_model #(.MT_BITS(MT)) enc_u (
        .mclk      (mclk),
        .encTurns  (encTurns),
        .encStrobe (encStrobe),
        .safeIn    (safeIn)
    );

    always #2 mclk = ~mclk;

    task automatic stopTest();
        if (badCount == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Callers sample one step past an edge, because the arguments are copied at the call.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge mclk);
        regWr     <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask

    task automatic waitTick(output int n);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end while (accelTick !== 1'b1 && n < 1000);
        if (accelTick !== 1'b1)
        begin
            badCount++;
            stopTest();
        end
    endtask

    task automatic testReset();
        rdChk(ADR_SUPPORT_EN, 32'h0);
        rdChk(ADR_RANGE_SEL, 32'h0);
        rdChk(ADR_TRIG_SRC, 32'h0);
        rdChk(ADR_HOME_VALUE, 32'h0);
        rdChk(ADR_ACCEL_INT, 32'h1);
        rdChk(ADR_FB_SEL, 32'h0);
        rdChk(ADR_STATUS, 32'h0);
        chk(absPosValid, 1'b0);
        wr(8'h30, 32'hffffffff);
        rdChk(8'h30, 32'h0);
        wr(ADR_STATUS, 32'hffffffff);
        rdChk(ADR_STATUS, 32'h0);
    endtask

    task automatic testConfig();
        wr(ADR_TRIG_SRC, 32'h5);
        rdChk(ADR_TRIG_SRC, 32'h0);
        wr(ADR_ACCEL_INT, 32'h0);
        rdChk(ADR_ACCEL_INT, 32'h1);
        wr(ADR_ACCEL_INT, 32'h65);
        rdChk(ADR_ACCEL_INT, 32'h1);
        wr(ADR_ACCEL_INT, 32'h64);
        rdChk(ADR_ACCEL_INT, 32'h64);
        for (int k = 3; k >= 0; k--)
        begin
            wr(ADR_FB_SEL, k);
            rdChk(ADR_FB_SEL, k);
        end
        wr(ADR_AXIS_CFG, 32'h1);
        rdChk(ADR_AXIS_CFG, 32'h1);
        chk(axisCfgEnabled, 1'b1);
    endtask

    task automatic testAccel();
        int n;
        wr(ADR_ACCEL_INT, 32'h2);
        repeat (50) @(posedge mclk);
        #1;
        chk(accelTick, 1'b0);
        wr(ADR_FB_SEL, 32'h1);
        waitTick(n);
        waitTick(n);
        chk(n, 2 * MSC);
    endtask

    task automatic testMismatch();
        wr(ADR_NV_POS, 32'h200);
        wr(ADR_NV_OFFSET, 32'h0);
        wr(ADR_SUPPORT_EN, 32'h1);
        enc_u.send(12'h100);
        chk(absPosValid, 1'b0);
        rdChk(ADR_STATUS, 32'h30);
    endtask

    // Each homing value sits inside the unsigned range, as the caller must ensure.
    task automatic testHoming();
        logic [3:0] masks [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
        wr(ADR_TRIG_SRC, 32'h5);
        wr(ADR_TRIG_SRC, 32'h7);
        rdChk(ADR_TRIG_SRC, 32'h5);
        for (int k = 1; k <= 6; k++)
        begin
            wr(ADR_TRIG_SRC, k);
            wr(ADR_HOME_VALUE, 32'h100 * k + 32'h11);
            enc_u.press(masks[k-1]);
            chk(absPosValid, 1'b1);
            chk(absPosition, 32'h100 * k + 32'h11);
            rdChk(ADR_NV_POS, 32'h100 * k + 32'h11);
        end
        wr(ADR_TRIG_SRC, 32'h0);
        wr(ADR_HOME_VALUE, 32'h5);
        enc_u.press(4'hf);
        chk(absPosition, 32'h611);
    endtask

    task automatic testRange();
        wr(ADR_TRIG_SRC, 32'h5);
        wr(ADR_HOME_VALUE, 32'h7ff);
        enc_u.press(4'h3);
        chk(absPosition, 32'h7ff);
        enc_u.send(12'h101);
        chk(absPosition, 32'h800);
        wr(ADR_RANGE_SEL, 32'h1);
        repeat (3) @(posedge mclk);
        #1;
        chk(absPosition, 32'hfffff800);
        enc_u.send(12'h900);
        chk(absPosition, 32'hffffffff);
        wr(ADR_RANGE_SEL, 32'h0);
        enc_u.send(12'h901);
        chk(absPosition, 32'h0);
    endtask

    task automatic testRevalid();
        wr(ADR_SUPPORT_EN, 32'h0);
        repeat (3) @(posedge mclk);
        #1;
        chk(absPosValid, 1'b0);
        chk(absPosition, 32'h0);
        wr(ADR_SUPPORT_EN, 32'h1);
        enc_u.send(12'h901);
        chk(absPosValid, 1'b1);
        rdChk(ADR_STATUS, 32'h21);
    endtask

    // A second reset must clear the settings but leave the retained position store alone.
    task automatic testMidReset();
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdChk(ADR_SUPPORT_EN, 32'h0);
        chk(absPosValid, 1'b0);
        chk(absPosition, 32'h0);
        rdChk(ADR_FB_SEL, 32'h0);
        rdChk(ADR_NV_OFFSET, 32'h6ff);
        chk(axisCfgEnabled, 1'b0);
    endtask

    initial
    begin
        mclk      = 1'b0;
        srst      = 1'b1;
        regAddr   = 8'h00;
        regWrData = 32'h0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        badCount  = 0;
        nTests    = 0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        testReset();
        testConfig();
        testAccel();
        testMismatch();
        testHoming();
        testRange();
        testRevalid();
        testMidReset();
        stopTest();
    end
endmodule

// >>> tb/spa_enc_model.sv
// Purpose: Encoder and safe input stand-in for the position block.
// Assumes: Turn count and safe inputs are synchronous to mclk.
// Notes: The count is held between strobes, as a real encoder keeps its last sample.
`timescale 1ns/1ps
module spa_enc_model #(
    parameter int MT_BITS = 12
)(
    input  wire logic               mclk,
    output logic      [MT_BITS-1:0] encTurns,
    output logic                    encStrobe,
    output logic      [3:0]         safeIn
);
    initial
    begin
        encTurns  = '0;
        encStrobe = 1'b0;
        safeIn    = 4'h0;
    end

    // The count is only as wide as the encoder, so no extra turn bits can appear.
    task automatic send(input logic [MT_BITS-1:0] turns);
        @(posedge mclk);
        encTurns  <= turns;
        encStrobe <= 1'b1;
        @(posedge mclk);
        encStrobe <= 1'b0;
        repeat (3) @(posedge mclk);
        // Returning just past the edge lets the caller sample settled outputs.
        #1;
    endtask

    // Inputs fall again afterwards because homing reacts to a rising edge only.
    task automatic press(input logic [3:0] mask);
        @(posedge mclk);
        safeIn <= mask;
        repeat (3) @(posedge mclk);
        safeIn <= 4'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
endmodule

// >>> verilog/spa_abs_position.sv
// Purpose: Safe absolute position check, presentation, homing and acceleration interval timing for one axis.
// Assumes: Encoder multi-turn count and safe inputs are synchronous to mclk.
// Notes: Registers sit on a plain address/strobe port with read data one cycle later.
// Summary of operation
// R1: Support enable bit turns absolute position handling off or on, off by default.
// R2: With support on, position valid only if encoder reading matches stored copy.
// R3: Mismatch flags position invalid until a safe homing is done.
// R4: Functions needing absolute position are used only with support on.
// R5: Range select shows unsigned when 0, signed when 1, unsigned by default.
// R6: Range size equals encoder multi-turn bits; no extra bits are added.
// R7: Moving past either range end wraps to the opposite end.
// R8: Range select and homing value act only with encoder configured and support on.
// R9: Homing source codes: 0 unused, 1-4 single inputs, 5 pair 1/2, 6 pair 3/4.
// R10: Homing source writable only with support on and encoder set; defaults 0.
// R11: Safe homing is performed whenever the valid indication reads 0.
// R12: Homing value in user units, default 0, is the position after homing.
// R13: Homing value must lie inside the presented range.
// R14: Acceleration interval is 1 to 100 ms, default 1 ms.
// R15: Acceleration interval applies only with an encoder configured.
// R16: Encoder source: 0 none, 1 and 2 digital links, 3 other serial; default 0.
// R17: Axis configuration flag is informational, set by configuration tools.
// R18: Homing loads homing value as position, stores it, marks position valid.
`timescale 1ns/1ps
module spa_abs_position
    import spa_pkg::*;
#(
    parameter int MT_BITS   = 12,
    parameter int MS_CYCLES_P = MS_CYCLES
)(
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic [7:0]         regAddr,
    input  wire logic [31:0]        regWrData,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [31:0]        regRdData,
    input  wire logic [MT_BITS-1:0] encTurns,
    input  wire logic               encStrobe,
    input  wire logic [3:0]         safeIn,
    output logic      [31:0]        absPosition,
    output logic                    absPosValid,
    output logic                    accelTick,
    output logic                    axisCfgEnabled
);
    localparam int MSW = $clog2(MS_CYCLES_P + 1);

    generate
        if (MT_BITS < 1 || MT_BITS > 31 || MS_CYCLES_P < 1)
        begin : g_bad
            $error("spa_abs_position: unsupported MT_BITS or MS_CYCLES_P");
        end
    endgenerate

    spa_nv_if #(.W(MT_BITS)) nv ();

    spa_nv_store #(.W(MT_BITS)) u_store (
        .mclk (mclk),
        .nv   (nv)
    );

    logic               supportEn_ff, nxt_supportEn;
    logic               rangeSel_ff,  nxt_rangeSel;
    logic [2:0]         trigSrc_ff,   nxt_trigSrc;
    logic [31:0]        homeVal_ff,   nxt_homeVal;
    logic [6:0]         accelInt_ff,  nxt_accelInt;
    logic               axisCfg_ff,   nxt_axisCfg;
    logic [1:0]         fbSel_ff,     nxt_fbSel;
    logic [MT_BITS-1:0] encRaw_ff,    nxt_encRaw;
    logic               trigLvl_ff,   nxt_trigLvl;
    spa_state_t         state_ff,     nxt_state;
    logic               valid_ff,     nxt_valid;
    logic [31:0]        pos_ff,       nxt_pos;
    logic [31:0]        rdData_ff,    nxt_rdData;
    logic [MSW-1:0]     msCnt_ff,     nxt_msCnt;
    logic [6:0]         intCnt_ff,    nxt_intCnt;
    logic               tick_ff,      nxt_tick;
    logic               gated;
    logic               encOn;
    logic               trigLvl;
    logic               homingReq;
    logic [MT_BITS-1:0] homeTurns;
    logic [MT_BITS-1:0] presNew;
    logic [MT_BITS-1:0] presCur;

    assign encOn     = (fbSel_ff != FB_NONE);
    assign gated     = supportEn_ff && encOn;                           // R8
    assign homeTurns = homeVal_ff[MT_BITS-1:0];                          // R13
    // Offset arithmetic is modulo the multi-turn width, which gives the wrap for free.
    assign presNew   = MT_BITS'(encTurns + nv.rdOff);                    // R6
    assign presCur   = MT_BITS'(encRaw_ff + nv.rdOff);                   // R7

    // Homing source decode and rising edge of the chosen input or pair.
    always_comb
    begin
        unique case (trigSrc_ff)                                         // R9
            3'h1:        trigLvl = safeIn[0];
            3'h2:        trigLvl = safeIn[1];
            3'h3:        trigLvl = safeIn[2];
            3'h4:        trigLvl = safeIn[3];
            SRC_DUAL_12: trigLvl = safeIn[0] && safeIn[1];
            SRC_DUAL_34: trigLvl = safeIn[2] && safeIn[3];
            default:     trigLvl = 1'b0;
        endcase
    end

    assign homingReq = gated && trigLvl && !trigLvl_ff;
    assign nxt_trigLvl = trigLvl;

    // Register writes.
    always_comb
    begin
        nxt_supportEn = supportEn_ff;
        nxt_rangeSel  = rangeSel_ff;
        nxt_trigSrc   = trigSrc_ff;
        nxt_homeVal   = homeVal_ff;
        nxt_accelInt  = accelInt_ff;
        nxt_axisCfg   = axisCfg_ff;
        nxt_fbSel     = fbSel_ff;
        if (regWr)
        begin
            unique case (regAddr)
                ADR_SUPPORT_EN: nxt_supportEn = regWrData[0];            // R1
                ADR_RANGE_SEL:  nxt_rangeSel  = regWrData[0];            // R5
                ADR_TRIG_SRC:
                    if (gated && regWrData[2:0] <= SRC_DUAL_34)
                        nxt_trigSrc = regWrData[2:0];                    // R10
                ADR_HOME_VALUE: nxt_homeVal   = regWrData;               // R12
                ADR_ACCEL_INT:
                    if (regWrData[31:7] == 25'h0 && regWrData[6:0] >= ACCEL_MIN_MS
                        && regWrData[6:0] <= ACCEL_MAX_MS)
                        nxt_accelInt = regWrData[6:0];                   // R14
                ADR_AXIS_CFG:   nxt_axisCfg   = regWrData[0];            // R17
                ADR_FB_SEL:     nxt_fbSel     = regWrData[1:0];          // R16
                default:        ;
            endcase
        end
    end

    // Validity state, position store traffic and presented position.
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_encRaw = encStrobe ? encTurns : encRaw_ff;
        nv.we      = 1'b0;
        nv.wrPos   = nv.rdPos;
        nv.wrOff   = nv.rdOff;
        if (!gated)
            nxt_state = ST_OFF;                                          // R1
        else if (homingReq)
        begin
            // Homing re-bases the offset so the present reading shows the homing value.
            nxt_state = ST_TRACK;                                        // R18
            nv.we     = 1'b1;
            nv.wrPos  = homeTurns;
            nv.wrOff  = MT_BITS'(homeTurns - encRaw_ff);
        end
        else
        begin
            unique case (state_ff)
                ST_OFF:     nxt_state = ST_CHECK;
                ST_CHECK:
                    if (encStrobe)
                        nxt_state = (presNew == nv.rdPos) ? ST_TRACK : ST_INVALID; // R2
                ST_TRACK:
                    if (encStrobe)
                    begin
                        nv.we    = 1'b1;
                        nv.wrPos = presNew;
                    end
                ST_INVALID: nxt_state = ST_INVALID;                      // R3
            endcase
        end
        if (!nv.we && regWr && regAddr == ADR_NV_POS)
        begin
            nv.we    = 1'b1;
            nv.wrPos = regWrData[MT_BITS-1:0];
        end
        else if (!nv.we && regWr && regAddr == ADR_NV_OFFSET)
        begin
            nv.we    = 1'b1;
            nv.wrOff = regWrData[MT_BITS-1:0];
        end
        nxt_valid = (nxt_state == ST_TRACK);                             // R11
        if (!gated)
            nxt_pos = 32'h0;
        else if (rangeSel_ff)
            nxt_pos = {{(32-MT_BITS){presCur[MT_BITS-1]}}, presCur};     // R5
        else
            nxt_pos = {{(32-MT_BITS){1'b0}}, presCur};
    end

    // Acceleration interval timing, counters held at zero while no encoder is linked.
    always_comb
    begin
        nxt_msCnt  = msCnt_ff;
        nxt_intCnt = intCnt_ff;
        nxt_tick   = 1'b0;
        if (!encOn)
        begin
            nxt_msCnt  = '0;                                             // R15
            nxt_intCnt = 7'h0;
        end
        else if (msCnt_ff == MSW'(MS_CYCLES_P - 1))
        begin
            nxt_msCnt = '0;
            if (intCnt_ff + 7'h1 >= accelInt_ff)
            begin
                nxt_intCnt = 7'h0;
                nxt_tick   = 1'b1;                                       // R14
            end
            else
                nxt_intCnt = intCnt_ff + 7'h1;
        end
        else
            nxt_msCnt = MSW'(msCnt_ff + 1'b1);
    end

    // Read mux; unmapped addresses read zero.
    always_comb
    begin
        nxt_rdData = 32'h0;
        if (regRd)
        begin
            unique case (regAddr)
                ADR_SUPPORT_EN: nxt_rdData = {31'h0, supportEn_ff};
                ADR_RANGE_SEL:  nxt_rdData = {31'h0, rangeSel_ff};
                ADR_TRIG_SRC:   nxt_rdData = {29'h0, trigSrc_ff};
                ADR_HOME_VALUE: nxt_rdData = homeVal_ff;
                ADR_ACCEL_INT:  nxt_rdData = {25'h0, accelInt_ff};
                ADR_AXIS_CFG:   nxt_rdData = {31'h0, axisCfg_ff};
                ADR_FB_SEL:     nxt_rdData = {30'h0, fbSel_ff};
                ADR_STATUS:
                begin
                    nxt_rdData[STAT_VALID_BIT] = valid_ff;
                    nxt_rdData[STAT_STATE_LSB +: 2] = state_ff;
                end
                ADR_POSITION:   nxt_rdData = pos_ff;
                ADR_NV_POS:     nxt_rdData = {{(32-MT_BITS){1'b0}}, nv.rdPos};
                ADR_NV_OFFSET:  nxt_rdData = {{(32-MT_BITS){1'b0}}, nv.rdOff};
                default:        nxt_rdData = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            supportEn_ff <= 1'b0;
            rangeSel_ff  <= 1'b0;
            trigSrc_ff   <= SRC_UNUSED;
            homeVal_ff   <= 32'h0;
            accelInt_ff  <= ACCEL_RST;
            axisCfg_ff   <= 1'b0;
            fbSel_ff     <= FB_NONE;
            encRaw_ff    <= '0;
            trigLvl_ff   <= 1'b0;
            state_ff     <= ST_OFF;
            valid_ff     <= 1'b0;
            pos_ff       <= 32'h0;
            rdData_ff    <= 32'h0;
            msCnt_ff     <= '0;
            intCnt_ff    <= 7'h0;
            tick_ff      <= 1'b0;
        end
        else
        begin
            supportEn_ff <= nxt_supportEn;
            rangeSel_ff  <= nxt_rangeSel;
            trigSrc_ff   <= nxt_trigSrc;
            homeVal_ff   <= nxt_homeVal;
            accelInt_ff  <= nxt_accelInt;
            axisCfg_ff   <= nxt_axisCfg;
            fbSel_ff     <= nxt_fbSel;
            encRaw_ff    <= nxt_encRaw;
            trigLvl_ff   <= nxt_trigLvl;
            state_ff     <= nxt_state;
            valid_ff     <= nxt_valid;
            pos_ff       <= nxt_pos;
            rdData_ff    <= nxt_rdData;
            msCnt_ff     <= nxt_msCnt;
            intCnt_ff    <= nxt_intCnt;
            tick_ff      <= nxt_tick;
        end
    end

    assign regRdData      = rdData_ff;
    assign absPosition    = pos_ff;
    assign absPosValid    = valid_ff;
    assign accelTick      = tick_ff;
    assign axisCfgEnabled = axisCfg_ff;

    property p_off_invalid;
        @(posedge mclk) disable iff (srst)
        !supportEn_ff |=> !absPosValid;
    endproperty
    a_off_invalid: assert property (p_off_invalid) else $error("Valid while support off."); // R1

    property p_check_result;
        @(posedge mclk) disable iff (srst)
        (state_ff == ST_CHECK && gated && !homingReq && encStrobe)
            |=> (absPosValid == ($past(presNew) == $past(nv.rdPos)));
    endproperty
    a_check_result: assert property (p_check_result) else $error("Check result wrong."); // R2

    property p_invalid_holds;
        @(posedge mclk) disable iff (srst)
        (state_ff == ST_INVALID && gated && !homingReq) |=> !absPosValid;
    endproperty
    a_invalid_holds: assert property (p_invalid_holds) else $error("Invalid cleared without homing."); // R3

    property p_signed_view;
        @(posedge mclk) disable iff (srst)
        (gated && rangeSel_ff) |=> (absPosition[31] == absPosition[MT_BITS-1]);
    endproperty
    a_signed_view: assert property (p_signed_view) else $error("Signed view not sign-extended."); // R5

    property p_unsigned_view;
        @(posedge mclk) disable iff (srst)
        !rangeSel_ff |=> (absPosition >> MT_BITS) == 32'h0;
    endproperty
    a_unsigned_view: assert property (p_unsigned_view) else $error("Unsigned view exceeds range."); // R7

    property p_src_locked;
        @(posedge mclk) disable iff (srst)
        (regWr && regAddr == ADR_TRIG_SRC && !gated) |=> $stable(trigSrc_ff);
    endproperty
    a_src_locked: assert property (p_src_locked) else $error("Homing source written while locked."); // R10

    property p_homing;
        @(posedge mclk) disable iff (srst)
        (homingReq && !regWr && !encStrobe) ##1 (gated && !encStrobe)
            |=> absPosValid && absPosition[MT_BITS-1:0] == $past(homeTurns, 2);
    endproperty
    a_homing: assert property (p_homing) else $error("Homing did not load position."); // R18

    property p_interval_range;
        @(posedge mclk) disable iff (srst)
        (accelInt_ff >= ACCEL_MIN_MS) && (accelInt_ff <= ACCEL_MAX_MS);
    endproperty
    a_interval_range: assert property (p_interval_range) else $error("Interval out of range."); // R14

    property p_no_tick;
        @(posedge mclk) disable iff (srst)
        !encOn ##1 !encOn |-> !accelTick;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("Tick without encoder."); // R15
endmodule

// >>> verilog/spa_nv_if.sv
// Purpose: Carries writes to and reads from the position store.
// Assumes: One write port, registered read data.
// Notes: The store keeps position and offset as a pair.
`timescale 1ns/1ps
interface spa_nv_if #(parameter int W = 12);
    logic         we;
    logic [W-1:0] wrPos;
    logic [W-1:0] wrOff;
    logic [W-1:0] rdPos;
    logic [W-1:0] rdOff;
    modport store (input we, input wrPos, input wrOff, output rdPos, output rdOff);
    modport user  (output we, output wrPos, output wrOff, input rdPos, input rdOff);
endinterface

// >>> verilog/spa_nv_store.sv
// Purpose: Non-volatile copy of the last known position and its offset.
// Assumes: Content survives reset, as a real retained store would.
// Notes: Read data come from the storage flops themselves.
`timescale 1ns/1ps
module spa_nv_store
    import spa_pkg::*;
#(
    parameter int W = 12
)(
    input  wire logic  mclk,
    spa_nv_if.store    nv
);
    logic [W-1:0] pos_ff;
    logic [W-1:0] off_ff;
    logic [W-1:0] nxt_pos;
    logic [W-1:0] nxt_off;

    // Reset is deliberately not applied: the store must outlive it.
    always_comb
    begin
        nxt_pos = nv.we ? nv.wrPos : pos_ff;
        nxt_off = nv.we ? nv.wrOff : off_ff;
    end

    always_ff @(posedge mclk)
    begin
        pos_ff <= nxt_pos;
        off_ff <= nxt_off;
    end

    assign nv.rdPos = pos_ff;
    assign nv.rdOff = off_ff;
endmodule

// >>> verilog/spa_pkg.sv
// Purpose: Shared constants and types for the safe absolute position block.
// Assumes: One axis, 32-bit register data, byte addresses on the register port.
// Notes: Timing counts derive from the clock period and the printed times.
package spa_pkg;
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          MS_TIME_PS      = 1000000000;
    localparam int          MS_CYCLES       = MS_TIME_PS / CLK_PERIOD_PS;
    localparam logic [6:0]  ACCEL_MIN_MS    = 7'h01;
    localparam logic [6:0]  ACCEL_MAX_MS    = 7'h64;
    localparam logic [6:0]  ACCEL_RST       = 7'h01;
    localparam logic [2:0]  SRC_UNUSED      = 3'h0;
    localparam logic [2:0]  SRC_DUAL_12     = 3'h5;
    localparam logic [2:0]  SRC_DUAL_34     = 3'h6;
    localparam logic [1:0]  FB_NONE         = 2'h0;
    localparam logic [7:0]  ADR_SUPPORT_EN  = 8'h00;
    localparam logic [7:0]  ADR_RANGE_SEL   = 8'h04;
    localparam logic [7:0]  ADR_TRIG_SRC    = 8'h08;
    localparam logic [7:0]  ADR_HOME_VALUE  = 8'h0c;
    localparam logic [7:0]  ADR_ACCEL_INT   = 8'h10;
    localparam logic [7:0]  ADR_AXIS_CFG    = 8'h14;
    localparam logic [7:0]  ADR_FB_SEL      = 8'h18;
    localparam logic [7:0]  ADR_STATUS      = 8'h1c;
    localparam logic [7:0]  ADR_POSITION    = 8'h20;
    localparam logic [7:0]  ADR_NV_POS      = 8'h24;
    localparam logic [7:0]  ADR_NV_OFFSET   = 8'h28;
    localparam int          STAT_VALID_BIT  = 0;
    localparam int          STAT_STATE_LSB  = 4;
    typedef enum logic [1:0] {ST_OFF, ST_CHECK, ST_TRACK, ST_INVALID} spa_state_t;
endpackage
